// ==== smc_defines.vh ====
// constants for the selfcheck / reboot / sleep control register block
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
`define SMC_CTRL1_ADDR      8'h2a
`define SMC_CTRL2_ADDR      8'h2b
`define SMC_CTRL2_RESET     8'h00
`define SMC_CTRL1_RESET     8'h08
`define SMC_BIT_SELFCHECK   7
`define SMC_BIT_REBOOT      6
`define SMC_BIT_UNUSED      5
`define SMC_SMODS_HI        4
`define SMC_SMODS_LO        3
`define SMC_BIT_SLPE        2
`define SMC_MODS_HI         1
`define SMC_MODS_LO         0
`define SMC_BIT_FREAD       1
`define SMC_BIT_ACTIVE      0
`define SMC_MODE_NORMAL     2'h0
`define SMC_MODE_LNLP       2'h1
`define SMC_MODE_HIRES      2'h2
`define SMC_MODE_LOWPWR     2'h3
`define SMC_STANDBY_CYCLES  8'h10
`define SMC_BOOT_CYCLES     8'h20
`define SMC_RECOVER_MS      1
`define SMC_CLK_KHZ         50000
`define SMC_RECOVER_CYCLES  (`SMC_RECOVER_MS * `SMC_CLK_KHZ)
`endif

// ==== smc_host_model.sv ====
// host processor model: single byte register writes and reads
`timescale 1ns/1ps
module smc_host_model (
  input  logic       clk,
  input  logic       linkReady,
  input  logic [7:0] regRdata,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  output logic       regWrite,
  output logic       regRead,
  output logic       viaI2c
);
  int k;
  initial begin
    {regAddr, regWdata, regWrite, regRead, viaI2c} = 19'h00000;
  end
  // released lines show the inverse, so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic i2c);
    @(posedge clk);
    {regAddr, regWdata, viaI2c, regWrite} <= {a, d, i2c, 1'b1};
    @(posedge clk);
    {regAddr, regWdata, regWrite} <= {~a, ~d, 1'b0}; // no ack awaited
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk);
    {regAddr, regRead} <= {~a, 1'b0};
    @(posedge clk);
    d = regRdata;
  endtask
  // after any reset wait for the link and keep a margin before talking
  task automatic settle();
    for (k = 0; k < 400 && linkReady !== 1'b1; k++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
endmodule // smc_host_model

// ==== smc_mode_ctrl.v ====
// selfcheck, reboot and sleep control register with its mode logic
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_mode_ctrl #(
  parameter RECOVER_CYCLES = `SMC_RECOVER_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  input  wire        viaI2c,
  input  wire [1:0]  fifoModeField,
  input  wire [1:0]  sleepRateSel,
  input  wire [2:0]  output_rate_sel,
  input  wire        fifoGateBlock,
  input  wire        sleepRequest,
  input  wire        wakeRequest,
  input  wire        resetPin,
  output reg  [7:0]  regRdata,
  output wire        ackSuppress,
  output wire        commReset,
  output wire        linkReady,
  output wire        selfcheck_enable,
  output wire        activeMode,
  output wire        fastRead,
  output wire        autoSleepEn,
  output wire [1:0]  sleepOsrMode,
  output wire [1:0]  wakeOsrMode,
  output wire [1:0]  effOsrMode,
  output wire        sleepRateOverride,
  output wire [10:0] osrRatio,
  output wire        inSleep,
  output reg         fifoFlush,
  output reg         debounceClear,
  output wire        blockRegReset
);
  reg  [7:0] ctrl2_q;
  reg  [7:0] ctrl2_d;
  reg  [1:0] ctrl1_q;
  reg  [1:0] ctrl1_d;
  reg        sleep_q;
  reg        sleep_d;
  reg        pinPrev_q;
  wire       pinPulse;
  wire       forceStandby;
  wire       bootBusy;
  wire       bootDone;
  wire       wrCtrl2;
  wire       wrCtrl1;
  wire       rebootWrite;
  wire [2:0] rateIdx;

  // rate code for each allowed sleep rate: 50, 12.5, 6.25, 1.56 Hz
  function [2:0] sleepRateToCode;
    input [1:0] s;
    begin
      case (s)
        2'h0:    sleepRateToCode = 3'h4;
        2'h1:    sleepRateToCode = 3'h5;
        2'h2:    sleepRateToCode = 3'h6;
        default: sleepRateToCode = 3'h7;
      endcase
    end
  endfunction

  assign wrCtrl2     = regWrite && (regAddr == `SMC_CTRL2_ADDR) && linkReady;
  assign wrCtrl1     = regWrite && (regAddr == `SMC_CTRL1_ADDR) && linkReady;
  assign rebootWrite = wrCtrl2 && regWdata[`SMC_BIT_REBOOT];
  // over I2C the data byte carrying the reboot is not acknowledged
  assign ackSuppress = rebootWrite && viaI2c;
  assign pinPulse    = resetPin && !pinPrev_q;
  // interfaces are held in reset from the reboot write through Standby and boot, not during recovery
  assign commReset     = rebootWrite || bootBusy;
  assign blockRegReset = bootDone;

  smc_reset_seq #(
    .RECOVER_CYCLES (RECOVER_CYCLES)
  ) u_seq (
    .clk           (clk),
    .rst_n         (rst_n),
    .rebootReq     (rebootWrite),
    .pinResetPulse (pinPulse),
    .activeNow     (ctrl1_q[`SMC_BIT_ACTIVE]),
    .forceStandby  (forceStandby),
    .bootBusy      (bootBusy),
    .bootDone      (bootDone),
    .linkReady     (linkReady)
  );

  // register update; boot completion restores defaults and drops the reboot bit
  always @* begin
    ctrl2_d = ctrl2_q;
    ctrl1_d = ctrl1_q;
    if (bootDone) begin
      ctrl2_d = `SMC_CTRL2_RESET;
      ctrl1_d = 2'h0;
    end else begin
      if (wrCtrl2) begin
        ctrl2_d = regWdata;
        ctrl2_d[`SMC_BIT_UNUSED] = 1'b0;
      end
      if (wrCtrl1) begin
        ctrl1_d[`SMC_BIT_ACTIVE] = regWdata[`SMC_BIT_ACTIVE];
        if (fifoModeField == 2'h0)
          ctrl1_d[`SMC_BIT_FREAD] = regWdata[`SMC_BIT_FREAD];
      end
      if (forceStandby)
        ctrl1_d[`SMC_BIT_ACTIVE] = 1'b0;
    end
  end

  assign selfcheck_enable = ctrl2_q[`SMC_BIT_SELFCHECK];
  assign autoSleepEn      = ctrl2_q[`SMC_BIT_SLPE];
  assign sleepOsrMode     = ctrl2_q[`SMC_SMODS_HI:`SMC_SMODS_LO];
  assign wakeOsrMode      = ctrl2_q[`SMC_MODS_HI:`SMC_MODS_LO];
  assign activeMode       = ctrl1_q[`SMC_BIT_ACTIVE];
  assign fastRead         = ctrl1_q[`SMC_BIT_FREAD];
  assign inSleep          = sleep_q;
  assign sleepRateOverride = autoSleepEn && sleep_q;
  assign effOsrMode = sleepRateOverride ? sleepOsrMode : wakeOsrMode;
  assign rateIdx    = sleepRateOverride ? sleepRateToCode(sleepRateSel) : output_rate_sel;

  smc_osr_lookup u_osr (
    .rateSel  (rateIdx),
    .modeSel  (effOsrMode),
    .osrRatio (osrRatio)
  );

  // sleep/wake state; leaving auto-sleep or Active returns to Wake
  always @* begin
    sleep_d = sleep_q;
    if (!autoSleepEn || !activeMode)
      sleep_d = 1'b0;
    else if (sleep_q && wakeRequest)
      sleep_d = 1'b0;
    else if (!sleep_q && sleepRequest)
      sleep_d = 1'b1;
  end

  // registers; status elsewhere is untouched by a transition, only flush and clear pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_q       <= `SMC_CTRL2_RESET;
      ctrl1_q       <= 2'h0;
      sleep_q       <= 1'b0;
      pinPrev_q     <= 1'b0;
      fifoFlush     <= 1'b0;
      debounceClear <= 1'b0;
    end else begin
      ctrl2_q       <= ctrl2_d;
      ctrl1_q       <= ctrl1_d;
      sleep_q       <= sleep_d;
      pinPrev_q     <= resetPin;
      debounceClear <= autoSleepEn && (sleep_d != sleep_q);
      fifoFlush     <= autoSleepEn && (sleep_d != sleep_q) && !fifoGateBlock;
    end
  end

  // read data registered on a read strobe; unmapped addresses read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `SMC_CTRL2_ADDR)
        regRdata <= {ctrl2_q[7:6], 1'b0, ctrl2_q[4:0]};
      else
        regRdata <= 8'h00;
    end
  end
endmodule // smc_mode_ctrl

// ==== smc_mode_ctrl_assertions.sv ====
// concurrent checks on the selfcheck, reboot and sleep control block
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_mode_ctrl_chk (
  input logic       clk,
  input logic       rst_n,
  input logic [7:0] regAddr,
  input logic [7:0] regWdata,
  input logic       regWrite,
  input logic       regRead,
  input logic       viaI2c,
  input logic [1:0] fifoModeField,
  input logic       linkReady,
  input logic       ackSuppress,
  input logic       commReset,
  input logic       fastRead,
  input logic       selfcheck_enable,
  input logic       autoSleepEn,
  input logic [1:0] sleepOsrMode,
  input logic [1:0] wakeOsrMode,
  input logic [1:0] effOsrMode,
  input logic       inSleep,
  input logic       fifoFlush,
  input logic       debounceClear,
  input logic [7:0] regRdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // accepted writes only; while the link recovers every write is dropped
  wire wr2b = regWrite && linkReady && regAddr == `SMC_CTRL2_ADDR;
  wire wr2a = regWrite && linkReady && regAddr == `SMC_CTRL1_ADDR;
  wire boot = wr2b && regWdata[`SMC_BIT_REBOOT];
  AST_NO_ACK: assert property (boot && viaI2c |-> ackSuppress)
    else $error("reboot byte acknowledged");
  AST_COMM_RST: assert property (boot |-> commReset ##1 !linkReady)
    else $error("link not reset on reboot");
  AST_LINK_HOLD: assert property ($fell(linkReady) |=> !linkReady [*4])
    else $error("link back too soon");
  AST_FREAD_KEEP: assert property (wr2a && fifoModeField != 2'h0 |=> $stable(fastRead))
    else $error("fast read changed with fifo on");
  AST_FREAD_SET: assert property (wr2a && fifoModeField == 2'h0 |=> fastRead == $past(regWdata[1]))
    else $error("fast read not written");
  AST_FIELDS: assert property (wr2b && !regWdata[6] |=>
    {selfcheck_enable, sleepOsrMode, autoSleepEn, wakeOsrMode} == {$past(regWdata[7]), $past(regWdata[4:0])})
    else $error("control fields not written");
  AST_BIT5: assert property (regRead && regAddr == `SMC_CTRL2_ADDR |=> !regRdata[5])
    else $error("unused bit reads one");
  AST_EFF: assert property (effOsrMode == ((inSleep && autoSleepEn) ? sleepOsrMode : wakeOsrMode))
    else $error("wrong oversampling mode in use");
  AST_ON_CHANGE: assert property ($changed(inSleep) && autoSleepEn |-> ##[0:2] debounceClear)
    else $error("no debounce clear on transition");
  AST_FLUSH_PULSE: assert property (fifoFlush |-> debounceClear ##1 !fifoFlush)
    else $error("flush pulse malformed");
  cover property (boot && viaI2c);
  cover property (fifoFlush);
  cover property (wr2a && fifoModeField != 2'h0);
endmodule // smc_mode_ctrl_chk
bind smc_mode_ctrl smc_mode_ctrl_chk chk_u (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .viaI2c,
  .fifoModeField, .linkReady, .ackSuppress, .commReset, .fastRead, .selfcheck_enable, .autoSleepEn,
  .sleepOsrMode, .wakeOsrMode, .effOsrMode, .inSleep, .fifoFlush, .debounceClear, .regRdata);

// ==== smc_osr_lookup.v ====
// oversampling ratio lookup by data rate code and oversampling mode
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_osr_lookup (
  input  wire [2:0]  rateSel,
  input  wire [1:0]  modeSel,
  output reg  [10:0] osrRatio
);
  // rows follow the data rate code 0 (800 Hz) to 7 (1.5625 Hz)
  always @* begin
    osrRatio = 11'h002;
    case (rateSel)
      3'h0: osrRatio = 11'h002;
      3'h1: osrRatio = (modeSel == `SMC_MODE_LOWPWR) ? 11'h002 : 11'h004;
      3'h2: osrRatio = (modeSel == `SMC_MODE_LOWPWR) ? 11'h002 : (modeSel == `SMC_MODE_HIRES) ? 11'h008 : 11'h004;
      3'h3: osrRatio = (modeSel == `SMC_MODE_LOWPWR) ? 11'h002 : (modeSel == `SMC_MODE_HIRES) ? 11'h010 : 11'h004;
      3'h4: osrRatio = (modeSel == `SMC_MODE_LOWPWR) ? 11'h002 : (modeSel == `SMC_MODE_HIRES) ? 11'h020 : 11'h004;
      3'h5: begin
        case (modeSel)
          `SMC_MODE_NORMAL: osrRatio = 11'h010;
          `SMC_MODE_LNLP:   osrRatio = 11'h004;
          `SMC_MODE_HIRES:  osrRatio = 11'h080;
          default:          osrRatio = 11'h002;
        endcase
      end
      3'h6: begin
        case (modeSel)
          `SMC_MODE_NORMAL: osrRatio = 11'h020;
          `SMC_MODE_LNLP:   osrRatio = 11'h008;
          `SMC_MODE_HIRES:  osrRatio = 11'h100;
          default:          osrRatio = 11'h004;
        endcase
      end
      default: begin
        case (modeSel)
          `SMC_MODE_NORMAL: osrRatio = 11'h080;
          `SMC_MODE_LNLP:   osrRatio = 11'h020;
          `SMC_MODE_HIRES:  osrRatio = 11'h400;
          default:          osrRatio = 11'h010;
        endcase
      end
    endcase
  end
endmodule // smc_osr_lookup

// ==== smc_reset_seq.v ====
// reboot sequencer: wait for Standby, run boot, then hold off the link
`timescale 1ns/1ps
`include "smc_defines.vh"
module smc_reset_seq #(
  parameter RECOVER_CYCLES = `SMC_RECOVER_CYCLES
) (
  input  wire clk,
  input  wire rst_n,
  input  wire rebootReq,
  input  wire pinResetPulse,
  input  wire activeNow,
  output wire forceStandby,
  output wire bootBusy,
  output reg  bootDone,
  output wire linkReady
);
  localparam [3:0] ST_IDLE    = 4'h1;
  localparam [3:0] ST_STANDBY = 4'h2;
  localparam [3:0] ST_BOOT    = 4'h4;
  localparam [3:0] ST_RECOVER = 4'h8;

  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg [7:0]  cnt_q;
  reg [7:0]  cnt_d;
  reg [31:0] recover_q;
  reg [31:0] recover_d;
  reg        done_d;

  assign forceStandby = (state_q != ST_IDLE) && (state_q != ST_RECOVER);
  assign bootBusy     = (state_q == ST_STANDBY) || (state_q == ST_BOOT);
  assign linkReady    = (state_q == ST_IDLE);

  // next state: pin pulse or reboot write both enter the same sequence
  always @* begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    recover_d = recover_q;
    done_d    = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (rebootReq || pinResetPulse) begin
          cnt_d = 8'h00;
          // already in Standby: skip the wind-down
          state_d = activeNow ? ST_STANDBY : ST_BOOT;
        end
      end
      ST_STANDBY: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == `SMC_STANDBY_CYCLES - 8'h01) begin
          cnt_d   = 8'h00;
          state_d = ST_BOOT;
        end
      end
      ST_BOOT: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_q == `SMC_BOOT_CYCLES - 8'h01) begin
          done_d    = 1'b1;
          recover_d = 32'h0;
          state_d   = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // link stays down so writes from a host that ignores the wait are dropped
        recover_d = recover_q + 32'h1;
        if (recover_q == RECOVER_CYCLES - 1)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // sequencer registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cnt_q     <= 8'h00;
      recover_q <= 32'h0;
      bootDone  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      recover_q <= recover_d;
      bootDone  <= done_d;
    end
  end
endmodule // smc_reset_seq

// ==== test_sensor_mode_control_reg.sv ====
// self-checking bench for the selfcheck, reboot and sleep control block
`timescale 1ns/1ps
`include "smc_defines.vh"
module test_sensor_mode_control_reg;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  fifoModeField = 2'h0;
  logic [1:0]  sleepRateSel = 2'h0;
  logic [2:0]  output_rate_sel = 3'h0;
  logic        fifoGateBlock = 1'b0, sleepRequest = 1'b0, wakeRequest = 1'b0, resetPin = 1'b0;
  logic [7:0]  regAddr, regWdata, regRdata, rd;
  logic        regWrite, regRead, viaI2c, linkReady, selfcheck_enable, activeMode, fastRead, ackSuppress;
  logic        autoSleepEn, sleepRateOverride, inSleep, fifoFlush, debounceClear, blockRegReset;
  logic [1:0]  wakeOsrMode, effOsrMode;
  logic [10:0] osrRatio;
  int          failures = 0, n_tests = 0, cyc = 0, nFlush = 0, nDeb = 0, nAck = 0, k;
  // rows: rate code, wake mode, expected ratio
  logic [15:0] rows [8] = '{{3'h7, 2'h0, 11'h080}, {3'h7, 2'h1, 11'h020}, {3'h7, 2'h2, 11'h400},
    {3'h7, 2'h3, 11'h010}, {3'h0, 2'h2, 11'h002}, {3'h5, 2'h2, 11'h080}, {3'h3, 2'h2, 11'h010},
    {3'h4, 2'h1, 11'h004}};
  always #10 clk = ~clk;
  smc_host_model host (.clk, .linkReady, .regRdata, .regAddr, .regWdata, .regWrite, .regRead, .viaI2c);
  // short recovery keeps each reboot to a few dozen cycles
  smc_mode_ctrl #(.RECOVER_CYCLES(8)) dut_u (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
    .viaI2c, .fifoModeField, .sleepRateSel, .output_rate_sel, .fifoGateBlock, .sleepRequest, .wakeRequest,
    .resetPin, .regRdata, .ackSuppress, .commReset(), .linkReady, .selfcheck_enable, .activeMode,
    .fastRead, .autoSleepEn, .sleepOsrMode(), .wakeOsrMode, .effOsrMode, .sleepRateOverride, .osrRatio,
    .inSleep, .fifoFlush, .debounceClear, .blockRegReset);
  // pulse counters and a hang limit well above the expected run
  always @(posedge clk) begin
    nFlush <= nFlush + int'(fifoFlush);
    nDeb <= nDeb + int'(debounceClear);
    nAck <= nAck + int'(ackSuppress);
    if (++cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic boot_wait();
    // look off the edge so the one-cycle pulse is seen while it stands
    for (k = 0; k < 300 && blockRegReset !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(11'(blockRegReset), 11'h001);
    // defaults land on the edge that ends the pulse
    @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      output_rate_sel <= rows[i][15:13];
      host.wr(`SMC_CTRL2_ADDR, {6'h00, rows[i][12:11]}, 1'b0);
      #1 chk(11'(wakeOsrMode), 11'(rows[i][12:11]));
      chk(osrRatio, rows[i][10:0]);
    end
    $display("test lookup done");
    @(posedge clk);
    {rst_n, output_rate_sel} <= {1'b0, 3'h0};
    @(posedge clk);
    rst_n <= 1'b1;
    host.rd(`SMC_CTRL2_ADDR, rd);
    chk(11'({activeMode, rd}), 11'h000);
    chk(osrRatio, 11'h002);
    $display("test reset done");
    fifoModeField <= 2'h1;
    host.wr(`SMC_CTRL1_ADDR, 8'h03, 1'b0);
    #1 chk(11'({fastRead, activeMode}), 11'h001);
    @(posedge clk);
    fifoModeField <= 2'h0;
    host.wr(`SMC_CTRL1_ADDR, 8'h03, 1'b0);
    #1 chk(11'(fastRead), 11'h001);
    $display("test fast read done");
    @(posedge clk);
    sleepRateSel <= 2'h3;
    host.wr(`SMC_CTRL2_ADDR, 8'hbf, 1'b0);
    host.rd(`SMC_CTRL2_ADDR, rd);
    chk(11'(rd), 11'h09f);
    sleepRequest <= 1'b1;
    for (k = 0; k < 50 && inSleep !== 1'b1; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1 chk(osrRatio, 11'h010);
    chk(11'({sleepRateOverride, 5'(nFlush), 5'(nDeb)}), 11'h421);
    {fifoGateBlock, sleepRequest, wakeRequest} <= 3'b101;
    for (k = 0; k < 50 && inSleep !== 1'b0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    #1 chk(11'({effOsrMode, selfcheck_enable}), 11'h007);
    chk(11'({5'(nFlush), 5'(nDeb)}), 11'h022);
    $display("test sleep done");
    // reboot byte also sets fields so only the boot can clear them
    host.wr(`SMC_CTRL2_ADDR, 8'hc4, 1'b1);
    #1 chk(11'(linkReady), 11'h000);
    @(posedge clk);
    #1 chk(11'(activeMode), 11'h000);
    boot_wait();
    chk(11'({activeMode, selfcheck_enable, fastRead, autoSleepEn}), 11'h000);
    // this write falls in the recovery window and must be dropped
    host.wr(`SMC_CTRL2_ADDR, 8'h84, 1'b0);
    host.settle();
    host.rd(`SMC_CTRL2_ADDR, rd);
    chk(11'(rd), 11'h000);
    chk(11'(nAck), 11'h001);
    $display("test reboot done");
    host.wr(`SMC_CTRL2_ADDR, 8'h80, 1'b0);
    resetPin <= 1'b1;
    @(posedge clk);
    resetPin <= 1'b0;
    boot_wait();
    host.settle();
    host.rd(`SMC_CTRL2_ADDR, rd);
    chk(11'(rd), 11'h000);
    $display("test pin reset done");
    end_sim();
  end
endmodule // test_sensor_mode_control_reg
